/* File: dv/pio_ext_pins.sv */
`timescale 1ns/1ns

module pio_ext_pins (
   input wire logic aclk,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe_n,
   input wire logic [31:0] pullup_en,
   input wire logic [31:0] ext_val,
   input wire logic [31:0] ext_en,
   output logic [31:0] pin_in
);
   // A pin that nobody holds flips every cycle, so a missing driver never reads as settled.
   logic [31:0] float_r = 32'h00000000;
   always_ff @(posedge aclk) begin
      float_r <= ~float_r;
   end
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pullup_en[i]) pin_in[i] = 1'b1;
         else pin_in[i] = float_r[i];
      end
   end
endmodule

/* File: dv/pio_top_monitor.sv */
`timescale 1ns/1ns
`include "pio_regs.svh"

module pio_top_monitor #(
   parameter int INPUT_ONLY_PIN = 29,
   parameter int OPEN_DRAIN_PIN_A = 16,
   parameter int OPEN_DRAIN_PIN_B = 17
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [`PIO_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic [`PIO_NPINS-1:0] pin_out,
   input wire logic [`PIO_NPINS-1:0] pin_oe_n,
   input wire logic [`PIO_NPINS-1:0] pullup_en
);
   logic bad_addr;
   assign bad_addr = s_axi_araddr > 8'h18 || s_axi_araddr[1:0] != 2'b00;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   input_only_a: assert property (pin_oe_n[INPUT_ONLY_PIN])
      else $error("input-only pin is driven");
   od_low_a: assert property (
      (!pin_oe_n[OPEN_DRAIN_PIN_A] |-> !pin_out[OPEN_DRAIN_PIN_A]) and
      (!pin_oe_n[OPEN_DRAIN_PIN_B] |-> !pin_out[OPEN_DRAIN_PIN_B]))
      else $error("open-drain pin drives high");
   pullup_input_a: assert property ((pullup_en & ~pin_oe_n) == 32'h0)
      else $error("pull-up on a driven pin");
   pullup_excl_a: assert property (
      !pullup_en[OPEN_DRAIN_PIN_A] && !pullup_en[OPEN_DRAIN_PIN_B] && !pullup_en[INPUT_ONLY_PIN])
      else $error("pull-up on an excluded pin");
   write_resp_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   read_ok_a: assert property (
      s_axi_arvalid && s_axi_arready && !bad_addr |=> s_axi_rvalid && s_axi_rresp == 2'b00)
      else $error("mapped read not answered okay");
   read_err_a: assert property (
      s_axi_arvalid && s_axi_arready && bad_addr |=> s_axi_rvalid && s_axi_rresp == 2'b10
      && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   wr_cov: cover property (s_axi_bvalid);
   rd_err_cov: cover property (s_axi_arvalid && s_axi_arready && bad_addr);
   od_cov: cover property (pin_oe_n[OPEN_DRAIN_PIN_A] && !pin_oe_n[OPEN_DRAIN_PIN_B]);
endmodule

/* File: dv/pio_top_test.sv */
`timescale 1ns/1ns
`include "pio_regs.svh"

module pio_top_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_wvalid = 1'b0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic ext_bus_mode = 1'b0;
   logic byte_bus_all_areas = 1'b0;
   logic dir_guard_unlock = 1'b0;
   logic [31:0] ext_val = 32'h0;
   logic [31:0] ext_en = 32'hffffffff;
   pio_pkg::pio_periph_t periph_out = {32'h00500000, 32'h00a00000, 32'h00300000};
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, pin_in, pin_out, pin_oe_n, pullup_en, periph_in;
   logic key_input_request;
   int error_cnt = 0;
   int checks = 0;
   logic [3:0] mux_exp;

   always #5 aclk = ~aclk;

   pio_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_bus_mode,
      .byte_bus_all_areas, .dir_guard_unlock, .periph_out, .pin_in, .pin_out, .pin_oe_n,
      .pullup_en, .periph_in, .key_input_request);
   pio_ext_pins ext (.aclk, .pin_out, .pin_oe_n, .pullup_en, .ext_val, .ext_en, .pin_in);

   task automatic give_verdict();
      if (error_cnt == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", nm, e, s);
         error_cnt++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      // One idle edge keeps the next call from raising what this one has just lowered.
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      chk("rdata", ed, s_axi_rdata);
      @(posedge aclk);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask

   initial begin
      tick(4);
      aresetn <= 1'b1;
      tick(4);
      for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0, `PIO_RESP_OKAY);
      wr(8'h1c, 32'hffffffff, `PIO_RESP_SLVERR);
      rd(8'h06, 32'h0, `PIO_RESP_SLVERR);
      // Pull-ups are set while the bus pins are still ports, never in a bus mode.
      s_axi_wstrb <= 4'h1;
      wr(`PIO_OFF_DIR, 32'hfffffff0, `PIO_RESP_OKAY);
      wr(`PIO_OFF_PULLUP, 32'h00000013, `PIO_RESP_OKAY);
      // Without lane zero the pull-up register keeps its value.
      s_axi_wstrb <= 4'he;
      wr(`PIO_OFF_PULLUP, 32'h00000000, `PIO_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      tick(2);
      chk("pullup_en", 32'h000c000f, pullup_en);
      wr(`PIO_OFF_DATA, 32'h000000a0, `PIO_RESP_OKAY);
      tick(2);
      chk("pin_oe_n", 32'hffffff0f, pin_oe_n);
      chk("pin_out", 32'h000000a0, pin_out & ~pin_oe_n);
      ext_en <= 32'hffffff0f;
      ext_val <= 32'h123456a5;
      tick(4);
      rd(`PIO_OFF_DATA, 32'h123456a5, `PIO_RESP_OKAY);
      chk("key request", 32'h1, {31'h0, key_input_request});
      wr(`PIO_OFF_SEL_C, 32'hffffffff, `PIO_RESP_OKAY);
      rd(`PIO_OFF_SEL_C, 32'h00300080, `PIO_RESP_OKAY);
      tick(4);
      chk("key request", 32'h0, {31'h0, key_input_request});
      chk("periph_in key", 32'h0, {28'h0, periph_in[19:16]});
      rd(`PIO_OFF_DATA, 32'h123056a5, `PIO_RESP_OKAY);
      ext_bus_mode <= 1'b1;
      wr(`PIO_OFF_DIR, 32'hffffffff, `PIO_RESP_OKAY);
      rd(`PIO_OFF_DIR, 32'h00ff00f0, `PIO_RESP_OKAY);
      dir_guard_unlock <= 1'b1;
      wr(`PIO_OFF_DIR, 32'hffffffff, `PIO_RESP_OKAY);
      rd(`PIO_OFF_DIR, 32'hdfff00f0, `PIO_RESP_OKAY);
      wr(`PIO_OFF_DATA, 32'h0000ff5f, `PIO_RESP_OKAY);
      tick(2);
      chk("bus latch", 32'h000000a0, pin_out & ~pin_oe_n & 32'h000000ff);
      byte_bus_all_areas <= 1'b1;
      wr(`PIO_OFF_PORT_CTRL, 32'h00000001, `PIO_RESP_OKAY);
      wr(`PIO_OFF_DIR, 32'h00f0ff00, `PIO_RESP_OKAY);
      rd(`PIO_OFF_DIR, 32'h00f0fff0, `PIO_RESP_OKAY);
      wr(`PIO_OFF_DATA, 32'h00000f00, `PIO_RESP_OKAY);
      tick(2);
      chk("od oe_n", 32'h0000000f, {24'h0, pin_oe_n[15:8]});
      chk("od level", 32'h0, {24'h0, pin_out[15:8]});
      for (int i = 0; i < 8; i++) begin
         wr(`PIO_OFF_SEL_A, i[2] ? 32'h00f00000 : 32'h0, `PIO_RESP_OKAY);
         wr(`PIO_OFF_SEL_B, i[1] ? 32'hffffffff : 32'h0, `PIO_RESP_OKAY);
         rd(`PIO_OFF_SEL_B, i[1] ? 32'h00f00000 : 32'h0, `PIO_RESP_OKAY);
         wr(`PIO_OFF_SEL_C, i[0] ? 32'h00300000 : 32'h0, `PIO_RESP_OKAY);
         tick(2);
         mux_exp = {i[1] ? 2'b10 : 2'b01, i[1] ? 2'b10 : (i[0] ? 2'b11 : 2'b01)};
         if (!i[2]) mux_exp = 4'h0;
         chk("mux", {28'h0, mux_exp}, {28'h0, pin_out[23:20]});
      end
      give_verdict();
   end

   initial begin
      tick(20000);
      error_cnt++;
      give_verdict();
   end
endmodule

bind pio_top pio_top_monitor #(.INPUT_ONLY_PIN(INPUT_ONLY_PIN),
   .OPEN_DRAIN_PIN_A(OPEN_DRAIN_PIN_A), .OPEN_DRAIN_PIN_B(OPEN_DRAIN_PIN_B)) mon (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .pin_out, .pin_oe_n, .pullup_en);

/* File: rtl/pio_axi_slave.sv */
`timescale 1ns/1ns
`include "pio_regs.svh"

module pio_axi_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`PIO_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`PIO_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic reg_wr,
   output logic [`PIO_ADDR_W-1:0] reg_waddr,
   output logic [31:0] reg_wdata,
   output logic [3:0] reg_wstrb,
   output logic [`PIO_ADDR_W-1:0] reg_raddr,
   input wire logic [31:0] reg_rdata
);

   logic aw_have_r;
   logic w_have_r;
   logic [`PIO_ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   assign reg_wr = aw_have_r && w_have_r && !s_axi_bvalid;
   assign reg_waddr = awaddr_r;
   assign reg_wdata = wdata_r;
   assign reg_wstrb = wstrb_r;
   assign reg_raddr = s_axi_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         awaddr_r <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (reg_wr) begin
         aw_have_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (reg_wr) begin
         w_have_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PIO_RESP_OKAY;
      end else if (reg_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= pio_pkg::pio_is_mapped(awaddr_r) ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `PIO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= reg_rdata;
         s_axi_rresp <= pio_pkg::pio_is_mapped(s_axi_araddr) ? `PIO_RESP_OKAY
                                                               : `PIO_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

/* File: rtl/pio_pin_mux.sv */
`timescale 1ns/1ns
`include "pio_regs.svh"

module pio_pin_mux #(
   parameter logic [`PIO_NPINS-1:0] HAS_P2_MASK = 32'h00000000,
   parameter logic [`PIO_NPINS-1:0] HAS_P3_MASK = 32'h00000000
) (
   input wire pio_pkg::pio_pin_cfg_t cfg,
   input wire pio_pkg::pio_periph_t periph,
   input wire logic [`PIO_NPINS-1:0] od_mask,
   output pio_pkg::pio_drive_t drive
);

   genvar i;
   generate
      for (i = 0; i < `PIO_NPINS; i = i + 1) begin : g_pin
         logic value;
         always_comb begin
            value = cfg.latch[i];
            if (cfg.sel_a[i]) begin
               value = periph.first[i];
               if (HAS_P3_MASK[i]) begin
                  if (cfg.sel_b[i]) begin
                     value = periph.second[i];
                  end else if (cfg.sel_c[i]) begin
                     value = periph.third[i];
                  end
               end else if (HAS_P2_MASK[i] && cfg.sel_b[i]) begin
                  value = periph.second[i];
               end
            end
         end
         // An open-drain pin never drives high: a one releases the pin instead.
         assign drive.level[i] = od_mask[i] ? 1'b0 : value;
         assign drive.oe_n[i] = !cfg.dir[i] || (od_mask[i] && value);
      end
   endgenerate

endmodule

/* File: rtl/pio_pkg.sv */
`include "pio_regs.svh"

package pio_pkg;

   typedef logic [`PIO_NPINS-1:0] pio_vec_t;

   typedef struct packed {
      pio_vec_t dir;
      pio_vec_t latch;
      pio_vec_t sel_a;
      pio_vec_t sel_b;
      pio_vec_t sel_c;
   } pio_pin_cfg_t;

   typedef struct packed {
      pio_vec_t level;
      pio_vec_t oe_n;
   } pio_drive_t;

   typedef struct packed {
      pio_vec_t first;
      pio_vec_t second;
      pio_vec_t third;
   } pio_periph_t;

   function automatic logic pio_is_mapped(input logic [`PIO_ADDR_W-1:0] addr);
      logic hit;
      hit = 1'b0;
      case (addr)
         `PIO_OFF_DIR, `PIO_OFF_DATA, `PIO_OFF_SEL_A, `PIO_OFF_SEL_B,
         `PIO_OFF_SEL_C, `PIO_OFF_PULLUP, `PIO_OFF_PORT_CTRL: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

endpackage

/* File: rtl/pio_regs.svh */
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

// Pin count of the modelled port group; the pin registers hold one bit per pin, the pull-up register one bit per four pins.
`define PIO_NPINS 32
`define PIO_ADDR_W 8

// Register byte offsets.
`define PIO_OFF_DIR 8'h00
`define PIO_OFF_DATA 8'h04
`define PIO_OFF_SEL_A 8'h08
`define PIO_OFF_SEL_B 8'h0c
`define PIO_OFF_SEL_C 8'h10
`define PIO_OFF_PULLUP 8'h14
`define PIO_OFF_PORT_CTRL 8'h18

// Field positions.
`define PIO_KEY_INHIBIT_BIT 7
`define PIO_OPEN_DRAIN_BIT 0

// Reset values.
`define PIO_RST_DIR 32'h00000000
`define PIO_RST_LATCH 32'h00000000
`define PIO_RST_SEL_A 32'h00000000
`define PIO_RST_SEL_B 32'h00000000
`define PIO_RST_SEL_C 32'h00000000
`define PIO_RST_PULLUP 8'h00
`define PIO_RST_PORT_CTRL 1'b0

// AXI response codes.
`define PIO_RESP_OKAY 2'b00
`define PIO_RESP_SLVERR 2'b10

`endif

/* File: rtl/pio_top.sv */
`timescale 1ns/1ns
`include "pio_regs.svh"

module pio_top #(
   parameter logic [`PIO_NPINS-1:0] BUS_PIN_MASK = 32'h0000ffff,
   parameter logic [`PIO_NPINS-1:0] PORT_ONE_MASK = 32'h0000ff00,
   parameter logic [`PIO_NPINS-1:0] DIR_GUARD_MASK = 32'hff000000,
   parameter logic [`PIO_NPINS-1:0] KEY_PIN_MASK = 32'h000f0000,
   parameter logic [`PIO_NPINS-1:0] HAS_P2_MASK = 32'h00f00000,
   parameter logic [`PIO_NPINS-1:0] HAS_P3_MASK = 32'h00300000,
   parameter int INPUT_ONLY_PIN = 29,
   parameter int OPEN_DRAIN_PIN_A = 16,
   parameter int OPEN_DRAIN_PIN_B = 17
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`PIO_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`PIO_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_bus_mode,
   input wire logic byte_bus_all_areas,
   input wire logic dir_guard_unlock,
   input wire pio_pkg::pio_periph_t periph_out,
   input wire logic [`PIO_NPINS-1:0] pin_in,
   output logic [`PIO_NPINS-1:0] pin_out,
   output logic [`PIO_NPINS-1:0] pin_oe_n,
   output logic [`PIO_NPINS-1:0] pullup_en,
   output logic [`PIO_NPINS-1:0] periph_in,
   output logic key_input_request
);

   localparam logic [`PIO_NPINS-1:0] ONE = 32'h00000001;
   localparam logic [`PIO_NPINS-1:0] INPUT_ONLY_MASK = ONE << INPUT_ONLY_PIN;
   localparam logic [`PIO_NPINS-1:0] OD_PIN_MASK = (ONE << OPEN_DRAIN_PIN_A) |
                                                   (ONE << OPEN_DRAIN_PIN_B);
   localparam logic [`PIO_NPINS-1:0] SEL_B_MASK = HAS_P2_MASK | HAS_P3_MASK;
   localparam int NGROUPS = `PIO_NPINS / 4;

   logic reg_wr;
   logic [`PIO_ADDR_W-1:0] reg_waddr;
   logic [31:0] reg_wdata;
   logic [3:0] reg_wstrb;
   logic [`PIO_ADDR_W-1:0] reg_raddr;
   logic [31:0] reg_rdata;

   logic [`PIO_NPINS-1:0] dir_r;
   logic [`PIO_NPINS-1:0] latch_r;
   logic [`PIO_NPINS-1:0] sel_a_r;
   logic [`PIO_NPINS-1:0] sel_b_r;
   logic [`PIO_NPINS-1:0] sel_c_r;
   logic [NGROUPS-1:0] pullup_r;
   logic port_one_od_r;
   logic [`PIO_NPINS-1:0] pin_meta_r;
   logic [`PIO_NPINS-1:0] pin_sync_r;

   logic [`PIO_NPINS-1:0] bus_lock;
   logic [`PIO_NPINS-1:0] dir_lock;
   logic [`PIO_NPINS-1:0] od_mask;
   logic [`PIO_NPINS-1:0] key_block;
   logic [`PIO_NPINS-1:0] pin_view;
   logic [`PIO_NPINS-1:0] pullup_nxt;
   logic key_inhibit;
   pio_pkg::pio_pin_cfg_t cfg;
   pio_pkg::pio_drive_t drive;

   // Byte lanes merged under a lock mask: locked bits keep their old value.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb, input logic [31:0] lock);
      logic [31:0] en;
      en = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & ~lock;
      return (old & ~en) | (data & en);
   endfunction

   pio_axi_slave u_axi (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .reg_wr(reg_wr),
      .reg_waddr(reg_waddr),
      .reg_wdata(reg_wdata),
      .reg_wstrb(reg_wstrb),
      .reg_raddr(reg_raddr),
      .reg_rdata(reg_rdata)
   );

   // Port one drops out of the bus when every external area runs a byte-wide bus.
   assign bus_lock = ext_bus_mode ?
                     (BUS_PIN_MASK & ~(byte_bus_all_areas ? PORT_ONE_MASK : '0)) : '0;
   assign dir_lock = bus_lock | INPUT_ONLY_MASK |
                     (dir_guard_unlock ? '0 : DIR_GUARD_MASK);
   assign key_inhibit = sel_c_r[`PIO_KEY_INHIBIT_BIT];
   assign key_block = key_inhibit ? KEY_PIN_MASK : '0;
   assign od_mask = OD_PIN_MASK | (port_one_od_r ? PORT_ONE_MASK : '0);
   assign pin_view = pin_sync_r & ~(key_block & ~dir_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_r <= `PIO_RST_DIR;
      end else if (reg_wr && reg_waddr == `PIO_OFF_DIR) begin
         dir_r <= merge(dir_r, reg_wdata, reg_wstrb, dir_lock) & ~INPUT_ONLY_MASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_r <= `PIO_RST_LATCH;
      end else if (reg_wr && reg_waddr == `PIO_OFF_DATA) begin
         latch_r <= merge(latch_r, reg_wdata, reg_wstrb, bus_lock | INPUT_ONLY_MASK);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_a_r <= `PIO_RST_SEL_A;
      end else if (reg_wr && reg_waddr == `PIO_OFF_SEL_A) begin
         sel_a_r <= merge(sel_a_r, reg_wdata, reg_wstrb, INPUT_ONLY_MASK);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_b_r <= `PIO_RST_SEL_B;
      end else if (reg_wr && reg_waddr == `PIO_OFF_SEL_B) begin
         sel_b_r <= merge(sel_b_r, reg_wdata, reg_wstrb, ~SEL_B_MASK);
      end
   end

   // The key-input inhibit shares this register with the third-level selects.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_c_r <= `PIO_RST_SEL_C;
      end else if (reg_wr && reg_waddr == `PIO_OFF_SEL_C) begin
         sel_c_r <= merge(sel_c_r, reg_wdata, reg_wstrb,
                          ~(HAS_P3_MASK | (ONE << `PIO_KEY_INHIBIT_BIT)));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pullup_r <= `PIO_RST_PULLUP;
      end else if (reg_wr && reg_waddr == `PIO_OFF_PULLUP && reg_wstrb[0]) begin
         pullup_r <= reg_wdata[NGROUPS-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_one_od_r <= `PIO_RST_PORT_CTRL;
      end else if (reg_wr && reg_waddr == `PIO_OFF_PORT_CTRL && reg_wstrb[0]) begin
         port_one_od_r <= reg_wdata[`PIO_OPEN_DRAIN_BIT];
      end
   end

   always_comb begin
      reg_rdata = '0;
      case (reg_raddr)
         `PIO_OFF_DIR: reg_rdata = dir_r;
         `PIO_OFF_DATA: reg_rdata = pin_view;
         `PIO_OFF_SEL_A: reg_rdata = sel_a_r;
         `PIO_OFF_SEL_B: reg_rdata = sel_b_r;
         `PIO_OFF_SEL_C: reg_rdata = sel_c_r;
         `PIO_OFF_PULLUP: reg_rdata = {{(32-NGROUPS){1'b0}}, pullup_r};
         `PIO_OFF_PORT_CTRL: reg_rdata = {31'h00000000, port_one_od_r};
         default: reg_rdata = '0;
      endcase
   end

   // Pins are asynchronous to aclk, so two stages precede every reader.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= pin_in;
         pin_sync_r <= pin_meta_r;
      end
   end

   assign cfg.dir = dir_r;
   assign cfg.latch = latch_r;
   assign cfg.sel_a = sel_a_r;
   assign cfg.sel_b = sel_b_r;
   assign cfg.sel_c = sel_c_r;

   pio_pin_mux #(
      .HAS_P2_MASK(HAS_P2_MASK),
      .HAS_P3_MASK(HAS_P3_MASK)
   ) u_mux (
      .cfg(cfg),
      .periph(periph_out),
      .od_mask(od_mask),
      .drive(drive)
   );

   // Registering the drive adds one cycle after a register write, but keeps pins glitch-free.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= '0;
         pin_oe_n <= '1;
      end else begin
         pin_out <= drive.level;
         pin_oe_n <= drive.oe_n | INPUT_ONLY_MASK;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NGROUPS; g = g + 1) begin : g_pull
         // The two fixed open-drain pins and the input-only pin have no pull-up resistor; port one keeps its pull-ups in open-drain mode.
         assign pullup_nxt[4*g+3:4*g] = {4{pullup_r[g]}} & ~dir_r[4*g+3:4*g] &
                                        ~OD_PIN_MASK[4*g+3:4*g] &
                                        ~INPUT_ONLY_MASK[4*g+3:4*g];
      end
   endgenerate

   // A single process owns the whole output so no bit has two writers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pullup_en <= '0;
      end else begin
         pullup_en <= pullup_nxt;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_in <= '0;
         key_input_request <= 1'b0;
      end else begin
         periph_in <= pin_view;
         // Key inputs are active low; the inhibit wins over any pin level.
         key_input_request <= !key_inhibit &&
                              |(KEY_PIN_MASK & ~dir_r & ~pin_sync_r);
      end
   end

endmodule
